/* File: design/cm_defs.svh */
// register offsets, field positions and reset values of the macrocell block
//
// Behaviour
// - the storage bit works as a D or a T flip-flop, chosen by configuration.
// - the flip-flop updates on the rising or falling edge, chosen by polarity.
// - two clock sources; the primary synchronous clock comes from outside.
// - the secondary clock is an outside pin or an internal logic equation.
// - two shared control terms drive preset and reset of the flip-flop.
// - preset and reset can be disabled, leaving only clocked updates.
// - after power-on reset the flip-flop holds zero.
// - one of the four remaining control terms can enable the output buffer.
// - the output buffer can instead be always enabled or always disabled.
// - global float pin low puts the output in high impedance regardless.
// - two feedbacks: macrocell value before the buffer, pin level after it.
// - as an input pin the buffer is off; both feedbacks stay usable.
// - six control terms, each configurable as sum term or product term.
// - preset and reset act without waiting for a macrocell clock edge.
`ifndef CM_DEFS_SVH
`define CM_DEFS_SVH

// apb byte addresses
`define CM_ADDR_W 12
`define CM_OFF_CFG 12'h000
`define CM_OFF_TERM_MODE 12'h004
`define CM_OFF_TERM_MASK 12'h008
`define CM_OFF_STATUS 12'h00C

// configuration field positions
`define CM_CFG_W 9
`define CM_CFG_T_MODE 0
`define CM_CFG_FALL 1
`define CM_CFG_CLK_SEL 2
`define CM_CFG_SEC_INT 3
`define CM_CFG_SETCLR_EN 4
`define CM_CFG_OE_MODE_LSB 5
`define CM_CFG_OE_SEL_LSB 7

// status field positions
`define CM_ST_Q 0
`define CM_ST_OE 1
`define CM_ST_PIN 2
`define CM_ST_CLK 3
`define CM_ST_TERM_LSB 4

// sizes and reset values
`define CM_N_TERMS 6
`define CM_TERM_IN 4
`define CM_CFG_RST 9'h000
`define CM_TERM_MODE_RST 6'h00
`define CM_TERM_MASK_RST 24'h000000

`endif

/* File: design/cm_pkg.sv */
// types shared by the macrocell block
package cm_pkg;

  // output buffer enable source
  typedef enum logic [1:0] {
    CM_OE_TERM = 2'h0,
    CM_OE_ON = 2'h1,
    CM_OE_OFF = 2'h2,
    CM_OE_RSVD = 2'h3
  } cm_oe_mode_t;

  // macrocell configuration word, msb first as laid out in the register
  typedef struct packed {
    logic [1:0] oe_term_sel;
    cm_oe_mode_t oe_mode;
    logic setclr_en;
    logic sec_internal;
    logic clk_sel;
    logic fall_edge;
    logic t_mode;
  } cm_cfg_t;

  // complete state of the macrocell top
  typedef struct packed {
    cm_cfg_t cfg;
    logic [5:0] term_mode;
    logic [23:0] term_mask;
    logic q;
    logic clk_prev;
    logic oe;
    logic pin_fb;
    logic [31:0] prdata;
    logic pslverr;
  } cm_state_t;

endpackage

/* File: design/cm_ctrl_terms.sv */
// control term evaluator: each term is a masked sum or product of its inputs
`timescale 1ns/1ps
module cm_ctrl_terms #(
  parameter int N_TERMS = 6,
  parameter int TERM_IN = 4
) (
  input wire logic [N_TERMS*TERM_IN-1:0] term_in_i,
  input wire logic [N_TERMS*TERM_IN-1:0] term_mask_i,
  input wire logic [N_TERMS-1:0] term_sum_i,
  output logic [N_TERMS-1:0] term_o
);

  // an empty mask gives zero in both forms so an unused term never fires
  genvar g;
  generate
    for (g = 0; g < N_TERMS; g++) begin : g_term
      logic [TERM_IN-1:0] in_v;
      logic [TERM_IN-1:0] msk_v;
      logic prod_v;
      logic sum_v;
      assign in_v = term_in_i[g*TERM_IN +: TERM_IN];
      assign msk_v = term_mask_i[g*TERM_IN +: TERM_IN];
      assign prod_v = (&(in_v | ~msk_v)) & (|msk_v);
      assign sum_v = |(in_v & msk_v);
      assign term_o[g] = term_sum_i[g] ? sum_v : prod_v;
    end
  endgenerate

endmodule

/* File: design/cm_macrocell.sv */
// one configurable macrocell with apb configuration, set/clear and output enable
//
// Register access over APB and the address map were decided locally.
`timescale 1ns/1ps
`include "cm_defs.svh"
module cm_macrocell
  import cm_pkg::*;
#(
  parameter int N_TERMS = `CM_N_TERMS,
  parameter int TERM_IN = `CM_TERM_IN
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  // apb slave
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [`CM_ADDR_W-1:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  // array side
  input wire logic d_i,
  input wire logic [N_TERMS*TERM_IN-1:0] term_in_i,
  input wire logic primary_sync_clock_i,
  input wire logic secondary_flexible_clock_i,
  input wire logic async_clk_eqn_i,
  // pin side
  input wire logic global_output_float_pin_n_i,
  input wire logic pin_i,
  output logic pin_o,
  output logic pin_oe_o,
  // interconnect matrix feedbacks
  output logic macrocell_fb_o,
  output logic pin_fb_o
);

  cm_state_t state_q;
  cm_state_t state_d;
  logic [N_TERMS-1:0] term_val;
  logic clk_now;
  logic edge_hit;
  logic next_q;
  logic oe_next;
  logic set_hit;
  logic clr_hit;
  logic [31:0] rd_word;
  logic rd_hit;

  // control terms, evaluated combinationally from the array inputs
  cm_ctrl_terms #(
    .N_TERMS(N_TERMS),
    .TERM_IN(TERM_IN)
  ) u_terms (
    .term_in_i(term_in_i),
    .term_mask_i(state_q.term_mask),
    .term_sum_i(state_q.term_mode),
    .term_o(term_val)
  );

  // clock source selection; edges found by comparing with the last sample.
  // a config change can look like an edge, so reconfigure with clocks quiet
  always_comb begin
    if (!state_q.cfg.clk_sel) begin
      clk_now = primary_sync_clock_i;
    end else if (state_q.cfg.sec_internal) begin
      clk_now = async_clk_eqn_i;
    end else begin
      clk_now = secondary_flexible_clock_i;
    end
    if (state_q.cfg.fall_edge) begin
      edge_hit = !clk_now && state_q.clk_prev;
    end else begin
      edge_hit = clk_now && !state_q.clk_prev;
    end
  end

  // flip-flop data path and set/clear terms
  always_comb begin
    if (state_q.cfg.t_mode) begin
      next_q = state_q.q ^ d_i;
    end else begin
      next_q = d_i;
    end
    set_hit = state_q.cfg.setclr_en && term_val[0];
    clr_hit = state_q.cfg.setclr_en && term_val[1];
  end

  // output enable source
  always_comb begin
    case (state_q.cfg.oe_mode)
      CM_OE_TERM: oe_next = term_val[2 + state_q.cfg.oe_term_sel];
      CM_OE_ON: oe_next = 1'b1;
      CM_OE_OFF: oe_next = 1'b0;
      default: oe_next = 1'b0;
    endcase
  end

  // read decode; data is captured in the setup cycle so it comes from flops
  always_comb begin
    rd_word = 32'h0000_0000;
    rd_hit = 1'b1;
    case (paddr_i)
      `CM_OFF_CFG: rd_word[`CM_CFG_W-1:0] = state_q.cfg;
      `CM_OFF_TERM_MODE: rd_word[N_TERMS-1:0] = state_q.term_mode;
      `CM_OFF_TERM_MASK: rd_word[23:0] = state_q.term_mask;
      `CM_OFF_STATUS: begin
        rd_word[`CM_ST_Q] = state_q.q;
        rd_word[`CM_ST_OE] = state_q.oe;
        rd_word[`CM_ST_PIN] = state_q.pin_fb;
        rd_word[`CM_ST_CLK] = state_q.clk_prev;
        rd_word[`CM_ST_TERM_LSB +: N_TERMS] = term_val;
      end
      default: rd_hit = 1'b0;
    endcase
  end

  // next state of the whole block
  always_comb begin
    state_d = state_q;
    if (ce_i) begin
      state_d.clk_prev = clk_now;
      if (clr_hit) begin
        state_d.q = 1'b0;
      end else if (set_hit) begin
        state_d.q = 1'b1;
      end else if (edge_hit) begin
        state_d.q = next_q;
      end
      state_d.oe = oe_next;
      state_d.pin_fb = pin_i;
      // apb setup phase latches the answer for the access phase
      if (psel_i && !penable_i) begin
        state_d.prdata = pwrite_i ? 32'h0000_0000 : rd_word;
        state_d.pslverr = !rd_hit;
      end
      // apb write takes effect at the access edge
      if (psel_i && penable_i && pwrite_i) begin
        case (paddr_i)
          `CM_OFF_CFG: state_d.cfg = cm_cfg_t'(pwdata_i[`CM_CFG_W-1:0]);
          `CM_OFF_TERM_MODE: state_d.term_mode = pwdata_i[N_TERMS-1:0];
          `CM_OFF_TERM_MASK: state_d.term_mask = pwdata_i[23:0];
          default: state_d.term_mode = state_q.term_mode;
        endcase
      end
    end
  end

  // state register; zero at reset
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      state_q <= '0;
      state_q.cfg <= cm_cfg_t'(`CM_CFG_RST);
      state_q.term_mode <= `CM_TERM_MODE_RST;
      state_q.term_mask <= `CM_TERM_MASK_RST;
    end else begin
      state_q <= state_d;
    end
  end

  // outputs; the float pin gates the enable directly so it acts at once
  assign pready_o = 1'b1;
  assign prdata_o = state_q.prdata;
  assign pslverr_o = state_q.pslverr;
  assign pin_o = state_q.q;
  assign pin_oe_o = state_q.oe && global_output_float_pin_n_i;
  assign macrocell_fb_o = state_q.q;
  assign pin_fb_o = state_q.pin_fb;

  // --- checks ---

  // one primary rising edge seen while the block was running
  sequence rise_primary_s;
    ce_i && $past(ce_i) && $rose(primary_sync_clock_i);
  endsequence

  // one primary falling edge seen while the block was running
  sequence fall_primary_s;
    ce_i && $past(ce_i) && $fell(primary_sync_clock_i);
  endsequence

  // an internal equation rising edge while running
  sequence rise_eqn_s;
    ce_i && $past(ce_i) && $rose(async_clk_eqn_i);
  endsequence

  // primary clock selected with no set/clear
  sequence plain_primary_s;
    !state_q.cfg.clk_sel && !state_q.cfg.setclr_en;
  endsequence

  property d_capture_p;
    @(posedge clk_i) disable iff (rst_i)
      (rise_primary_s ##0 plain_primary_s ##0
       (!state_q.cfg.t_mode && !state_q.cfg.fall_edge)) |=> macrocell_fb_o == $past(d_i);
  endproperty
  d_mode_capture_a: assert property (d_capture_p)
    else $error("d mode did not capture input on rising edge");

  property toggle_p;
    @(posedge clk_i) disable iff (rst_i)
      (rise_primary_s ##0 plain_primary_s ##0
       (state_q.cfg.t_mode && !state_q.cfg.fall_edge)) |=>
        macrocell_fb_o == ($past(macrocell_fb_o) ^ $past(d_i));
  endproperty
  t_mode_toggle_a: assert property (toggle_p)
    else $error("t mode did not toggle or hold correctly");

  property fall_ignore_p;
    @(posedge clk_i) disable iff (rst_i)
      (rise_primary_s ##0 plain_primary_s ##0 state_q.cfg.fall_edge) |=> $stable(macrocell_fb_o);
  endproperty
  fall_pol_hold_a: assert property (fall_ignore_p)
    else $error("falling polarity reacted to rising edge");

  property fall_capture_p;
    @(posedge clk_i) disable iff (rst_i)
      (fall_primary_s ##0 plain_primary_s ##0
       (state_q.cfg.fall_edge && !state_q.cfg.t_mode)) |=> macrocell_fb_o == $past(d_i);
  endproperty
  fall_pol_capture_a: assert property (fall_capture_p)
    else $error("falling polarity missed falling edge");

  property eqn_clock_p;
    @(posedge clk_i) disable iff (rst_i)
      (rise_eqn_s ##0 (state_q.cfg.clk_sel && state_q.cfg.sec_internal &&
       !state_q.cfg.fall_edge && !state_q.cfg.t_mode && !state_q.cfg.setclr_en))
        |=> macrocell_fb_o == $past(d_i);
  endproperty
  eqn_clock_edge_a: assert property (eqn_clock_p)
    else $error("internal equation clock did not clock the flip-flop");

  property preset_p;
    @(posedge clk_i) disable iff (rst_i)
      (ce_i && state_q.cfg.setclr_en && term_val[0] && !term_val[1]) |=> macrocell_fb_o;
  endproperty
  preset_async_a: assert property (preset_p)
    else $error("preset term did not set the flip-flop");

  property clear_p;
    @(posedge clk_i) disable iff (rst_i)
      (ce_i && state_q.cfg.setclr_en && term_val[1]) |=> !macrocell_fb_o ##1 1'b1;
  endproperty
  clear_term_a: assert property (clear_p)
    else $error("clear term did not clear the flip-flop");

  property setclr_off_p;
    @(posedge clk_i) disable iff (rst_i)
      (ce_i && $past(ce_i) && !state_q.cfg.setclr_en && !state_q.cfg.clk_sel &&
       $stable(primary_sync_clock_i)) |=> $stable(macrocell_fb_o);
  endproperty
  setclr_disabled_a: assert property (setclr_off_p)
    else $error("disabled set/clear still changed the flip-flop");

  property reset_zero_p;
    @(posedge clk_i) $fell(rst_i) |-> !macrocell_fb_o && !pin_oe_o;
  endproperty
  reset_value_zero_a: assert property (reset_zero_p)
    else $error("flip-flop not zero after reset");

  property oe_term_p;
    @(posedge clk_i) disable iff (rst_i)
      (ce_i && state_q.cfg.oe_mode == CM_OE_TERM && global_output_float_pin_n_i) ##1
        global_output_float_pin_n_i |-> pin_oe_o == $past(term_val[2 + state_q.cfg.oe_term_sel]);
  endproperty
  oe_term_sel_a: assert property (oe_term_p)
    else $error("output enable does not follow selected term");

  property oe_fixed_p;
    @(posedge clk_i) disable iff (rst_i)
      (ce_i && state_q.cfg.oe_mode == CM_OE_OFF) |=> !pin_oe_o;
  endproperty
  oe_fixed_off_a: assert property (oe_fixed_p)
    else $error("output enabled while fixed off");

  property float_p;
    @(posedge clk_i) disable iff (rst_i)
      !global_output_float_pin_n_i |-> !pin_oe_o;
  endproperty
  global_float_a: assert property (float_p)
    else $error("output driven while global float is low");

  property pin_fb_p;
    @(posedge clk_i) disable iff (rst_i)
      ce_i |=> pin_fb_o == $past(pin_i) && macrocell_fb_o == pin_o;
  endproperty
  feedback_paths_a: assert property (pin_fb_p)
    else $error("feedback paths do not carry pin and macrocell");

  property term0_p;
    @(posedge clk_i) disable iff (rst_i)
      term_val[0] == (state_q.term_mode[0] ?
        |(term_in_i[3:0] & state_q.term_mask[3:0]) :
        ((&(term_in_i[3:0] | ~state_q.term_mask[3:0])) & (|state_q.term_mask[3:0])));
  endproperty
  term_sum_prod_a: assert property (term0_p)
    else $error("control term form wrong");

  // one secondary pin rising edge while running
  sequence rise_sec_s;
    ce_i && $past(ce_i) && $rose(secondary_flexible_clock_i);
  endsequence

  property sec_toggle_p;
    @(posedge clk_i) disable iff (rst_i)
      (rise_sec_s ##0 (state_q.cfg.clk_sel && !state_q.cfg.sec_internal &&
       state_q.cfg.t_mode && !state_q.cfg.fall_edge && !state_q.cfg.setclr_en))
        |=> macrocell_fb_o == ($past(macrocell_fb_o) ^ $past(d_i));
  endproperty
  sec_pin_clock_a: assert property (sec_toggle_p)
    else $error("secondary pin clock did not toggle the flip-flop");

  property eqn_toggle_p;
    @(posedge clk_i) disable iff (rst_i)
      (rise_eqn_s ##0 (state_q.cfg.clk_sel && state_q.cfg.sec_internal &&
       state_q.cfg.t_mode && !state_q.cfg.fall_edge && !state_q.cfg.setclr_en))
        |=> macrocell_fb_o == ($past(macrocell_fb_o) ^ $past(d_i));
  endproperty
  eqn_toggle_a: assert property (eqn_toggle_p)
    else $error("equation clock did not toggle in t mode");

  property oe_on_p;
    @(posedge clk_i) disable iff (rst_i)
      (ce_i && state_q.cfg.oe_mode == CM_OE_ON && global_output_float_pin_n_i) ##1
        global_output_float_pin_n_i |-> pin_oe_o;
  endproperty
  oe_fixed_on_a: assert property (oe_on_p)
    else $error("output disabled while fixed on");

  property input_fb_p;
    @(posedge clk_i) disable iff (rst_i)
      (ce_i && !pin_oe_o) |=> pin_fb_o == $past(pin_i);
  endproperty
  input_pin_fb_a: assert property (input_fb_p)
    else $error("input pin level not fed back");

endmodule

/* File: tb/cm_board.sv */
// board-side model of the shared pin wire for the macrocell bench
`timescale 1ns/1ps
module cm_board (
  input wire logic clk_i,
  input wire logic pin_o_i,
  input wire logic pin_oe_i,
  input wire logic drv_en_i,
  input wire logic drv_val_i,
  output logic wire_o
);
  logic last_q = 1'b0;
  // buffer off lets board drive
  // a floating wire flips every cycle so a stale level is never mistaken for data
  assign wire_o = pin_oe_i ? pin_o_i : (drv_en_i ? drv_val_i : ~last_q);
  // remember the wire for the floating pattern
  always_ff @(posedge clk_i) begin
    last_q <= wire_o;
  end
endmodule

/* File: tb/cpld_macrocell_test.sv */
// self-checking bench for the macrocell: apb setup, clocking, set/clear, pin paths
`timescale 1ns/1ps
`include "cm_defs.svh"
`define CHK(g, e) check_eq(32'(g), 32'(e))
module cpld_macrocell_test;
  import cm_pkg::*;
  logic clk, rst, psel, penable, pwrite, d, float_n, pin_w, pin_o, pin_oe;
  logic pready, pslverr, mfb, pfb, drv_en, drv_val;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata;
  logic [23:0] tin;
  logic [2:0] clks;
  int num_errors = 0;
  int checks_done = 0;

  cm_macrocell i_cm_macrocell (.clk_i(clk), .rst_i(rst), .ce_i(1'b1), .psel_i(psel),
    .penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata),
    .prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr), .d_i(d), .term_in_i(tin),
    .primary_sync_clock_i(clks[0]), .secondary_flexible_clock_i(clks[1]),
    .async_clk_eqn_i(clks[2]), .global_output_float_pin_n_i(float_n), .pin_i(pin_w),
    .pin_o(pin_o), .pin_oe_o(pin_oe), .macrocell_fb_o(mfb), .pin_fb_o(pfb));
  cm_board i_cm_board (.clk_i(clk), .pin_o_i(pin_o), .pin_oe_i(pin_oe),
    .drv_en_i(drv_en), .drv_val_i(drv_val), .wire_o(pin_w));

  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  task automatic check_eq(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      num_errors++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic report_and_stop;
    $display("errors %0d checks %0d", num_errors, checks_done);
    if (num_errors == 0 && checks_done > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask

  // one apb transfer; the request stands until pready is seen high
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd,
                     output logic [31:0] rd, output logic er);
    int n;
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 16);
    if (n >= 16) begin
      num_errors++;
      report_and_stop();
    end
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] wd);
    logic [31:0] rd;
    logic er;
    apb(1'b1, a, wd, rd, er);
  endtask

  // settle: let n edges land, then look just after the last one
  task automatic step(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  // full high-then-low cycle on one macrocell clock source
  task automatic pulse(input int k);
    @(posedge clk);
    clks[k] <= 1'b1;
    step(2);
    @(posedge clk);
    clks[k] <= 1'b0;
    step(2);
  endtask

  task automatic t_reset_regs;
    logic [31:0] rd;
    logic er;
    for (int i = 0; i < 4; i++) begin
      apb(1'b0, 12'(i * 4), 32'h0, rd, er);
      `CHK(rd, 0);
      `CHK(er, 0);
    end
    `CHK(mfb, 0);
    `CHK(pin_oe, 0);
    apb(1'b0, 12'h010, 32'h0, rd, er);
    `CHK(er, 1);
    wr(`CM_OFF_STATUS, 32'hFFFFFFFF);
    apb(1'b0, `CM_OFF_STATUS, 32'h0, rd, er);
    `CHK(rd, 0);
  endtask

  task automatic t_d_edges;
    wr(`CM_OFF_CFG, 32'h020);
    @(posedge clk);
    d <= 1'b1;
    pulse(0);
    `CHK(mfb, 1);
    `CHK(pin_o, 1);
    `CHK(pfb, 1);
    `CHK(pin_oe, 1);
    wr(`CM_OFF_CFG, 32'h022);
    @(posedge clk);
    d <= 1'b0;
    clks[0] <= 1'b1;
    step(2);
    `CHK(mfb, 1);
    @(posedge clk);
    clks[0] <= 1'b0;
    step(2);
    `CHK(mfb, 0);
  endtask

  task automatic t_toggle;
    wr(`CM_OFF_CFG, 32'h025);
    @(posedge clk);
    d <= 1'b1;
    pulse(1);
    `CHK(mfb, 1);
    pulse(1);
    `CHK(mfb, 0);
    @(posedge clk);
    d <= 1'b0;
    pulse(1);
    `CHK(mfb, 0);
    wr(`CM_OFF_CFG, 32'h02D);
    @(posedge clk);
    d <= 1'b1;
    pulse(1);
    `CHK(mfb, 0);
    pulse(2);
    `CHK(mfb, 1);
  endtask

  task automatic t_setclr;
    wr(`CM_OFF_TERM_MASK, 32'h11);
    wr(`CM_OFF_CFG, 32'h020);
    @(posedge clk);
    tin <= 24'h000010;
    step(2);
    `CHK(mfb, 1);
    wr(`CM_OFF_CFG, 32'h030);
    step(1);
    `CHK(mfb, 0);
    @(posedge clk);
    tin <= 24'h000001;
    step(2);
    `CHK(mfb, 1);
    @(posedge clk);
    tin <= 24'h000011;
    step(2);
    `CHK(mfb, 0);
  endtask

  task automatic t_oe;
    logic [23:0] one;
    wr(`CM_OFF_TERM_MASK, 32'h111100);
    for (int s = 0; s < 4; s++) begin
      one = 24'h1 << (4 * (2 + s));
      wr(`CM_OFF_CFG, 32'(s << 7));
      @(posedge clk);
      tin <= 24'h111100 & ~one;
      step(2);
      `CHK(pin_oe, 0);
      @(posedge clk);
      tin <= one;
      step(2);
      `CHK(pin_oe, 1);
    end
    @(posedge clk);
    float_n <= 1'b0;
    step(0);
    `CHK(pin_oe, 0);
    @(posedge clk);
    float_n <= 1'b1;
    wr(`CM_OFF_CFG, 32'h040);
    step(1);
    `CHK(pin_oe, 0);
    wr(`CM_OFF_CFG, 32'h060);
    step(1);
    `CHK(pin_oe, 0);
    @(posedge clk);
    drv_val <= 1'b1;
    step(2);
    `CHK(pfb, 1);
    `CHK(mfb, 0);
    wr(`CM_OFF_TERM_MASK, 32'h300);
    wr(`CM_OFF_CFG, 32'h000);
    @(posedge clk);
    tin <= 24'h000100;
    step(2);
    `CHK(pin_oe, 0);
    wr(`CM_OFF_TERM_MODE, 32'h04);
    step(2);
    `CHK(pin_oe, 1);
  endtask

  initial begin
    {rst, psel, penable, pwrite, d, drv_val} = 6'h20;
    {float_n, drv_en} = 2'h3;
    paddr = 12'h000;
    pwdata = 32'h0;
    tin = 24'h000000;
    clks = 3'h0;
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    t_reset_regs();
    t_d_edges();
    t_toggle();
    t_setclr();
    t_oe();
    report_and_stop();
  end
endmodule
